// *** include/lbx_pkg.sv ***
/*
  Shared constants and types of the ladder bit-logic executor.
  Assumes one 16-bit instruction word per program address.
*/
`default_nettype none
package lbx_pkg;

  // --------------------------------------------------------------
  // Instruction word layout
  // --------------------------------------------------------------
  localparam int IW      = 16;
  localparam int OPC_W   = 4;
  localparam int OPC_LSB = 12;
  localparam int OPR_W   = 12;
  localparam int OPR_LSB = 0;

  // --------------------------------------------------------------
  // Opcodes; end is identified by its own function code
  // --------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NOP      = 4'h0,
    OP_LOAD     = 4'h1,
    OP_LOAD_INV = 4'h2,
    OP_AND      = 4'h3,
    OP_AND_INV  = 4'h4,
    OP_OR       = 4'h5,
    OP_OR_INV   = 4'h6,
    OP_OUT      = 4'h7,
    OP_OUT_INV  = 4'h8,
    OP_END      = 4'hF
  } lbx_op_t;

  // --------------------------------------------------------------
  // Sequencer states, one-hot
  // --------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_SCAN     = 8'h01,
    ST_SCAN_CHK = 8'h02,
    ST_FETCH    = 8'h04,
    ST_DECODE   = 8'h08,
    ST_OPERAND  = 8'h10,
    ST_EXEC     = 8'h20,
    ST_WRITE    = 8'h40,
    ST_HALT     = 8'h80
  } lbx_state_t;

  // --------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------
  localparam logic       COND_RESET = 1'b0;
  localparam int         PC_START   = 0;
  localparam lbx_state_t STATE_RESET = ST_SCAN;

endpackage : lbx_pkg
`default_nettype wire

// *** rtl/lbx_cond_unit.sv ***
/*
  Execution condition register with its load, and, or logic.
  Assumes the operand bit is valid in the cycle exec_i is high.
*/
`default_nettype none
module lbx_cond_unit
  import lbx_pkg::*;
(
  input  wire logic    clk_i,
  input  wire logic    reset_i,
  input  wire logic    exec_i,
  input  wire lbx_op_t op_i,
  input  wire logic    bit_i,
  output var  logic    cond_o
);

  logic cond;
  logic next_cond;

  // --------------------------------------------------------------
  // Next condition
  // --------------------------------------------------------------
  always_comb begin
    next_cond = cond;
    if (exec_i) begin
      case (op_i)
        OP_LOAD:     next_cond = bit_i;
        OP_LOAD_INV: next_cond = ~bit_i;
        OP_AND:      next_cond = cond & bit_i;
        OP_AND_INV:  next_cond = cond & ~bit_i;
        OP_OR:       next_cond = cond | bit_i;
        OP_OR_INV:   next_cond = cond | ~bit_i;
        default:     next_cond = cond;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cond <= COND_RESET;
    end else begin
      cond <= next_cond;
    end
  end

  assign cond_o = cond;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  load_fresh_a: assert property (@(posedge clk_i)
    disable iff (reset_i)
    exec_i && op_i == OP_LOAD |=> cond == $past(bit_i))
    else $error("load did not copy operand bit");

  load_inv_a: assert property (@(posedge clk_i)
    disable iff (reset_i)
    exec_i && op_i == OP_LOAD_INV |=> cond != $past(bit_i))
    else $error("inverted load did not complement bit");

  and_combine_a: assert property (@(posedge clk_i)
    disable iff (reset_i)
    exec_i && op_i == OP_AND |=> cond == ($past(cond) & $past(bit_i)))
    else $error("and result wrong");

  and_inv_a: assert property (@(posedge clk_i)
    disable iff (reset_i)
    exec_i && op_i == OP_AND_INV |=> cond == ($past(cond) & !$past(bit_i)))
    else $error("inverted and result wrong");

  or_combine_a: assert property (@(posedge clk_i)
    disable iff (reset_i)
    exec_i && op_i == OP_OR |=> cond == ($past(cond) | $past(bit_i)))
    else $error("or result wrong");

  or_inv_a: assert property (@(posedge clk_i)
    disable iff (reset_i)
    exec_i && op_i == OP_OR_INV |=> cond == ($past(cond) | !$past(bit_i)))
    else $error("inverted or result wrong");

  cond_hold_a: assert property (@(posedge clk_i)
    disable iff (reset_i)
    !exec_i |=> $stable(cond))
    else $error("condition changed without an instruction");

endmodule : lbx_cond_unit
`default_nettype wire

// *** rtl/lbx_executor.sv ***
/*
  Ladder bit-logic executor: fetches one-word instructions, evaluates
  the execution condition and writes output bits.
  Assumes program and data memories on CLK_I with one-cycle read data.
*/
`default_nettype none
// How it works
// - Blocks open with load or inverted load, dropping old condition.
// - Load copies the addressed operand bit into the condition.
// - Inverted load copies the complement of the operand bit.
// - And combines condition with operand bit.
// - Inverted and combines condition with complemented operand bit.
// - Or combines condition with operand bit.
// - Inverted or combines condition with complemented operand bit.
// - Mixed and/or apply in program order on the running condition.
// - Output writes the condition into the addressed bit.
// - Inverted output writes the complemented condition.
// - Each bit-logic and output instruction takes exactly one program word.
// - Execute up to the first end, then restart at address zero.
// - Nothing after the first end is ever executed.
// - With no end in program memory, nothing executes.
// - End is recognised by its function code in the instruction word.
// - Operands may be any bit of every data zone.
// - Program addresses start at zero, one instruction per address.
module lbx_executor
  import lbx_pkg::*;
#(
  parameter int AW = 12
) (
  input  wire logic             CLK_I,
  input  wire logic             RESET_I,
  output var  logic [AW-1:0]    PM_ADDR_O,
  output var  logic             PM_RD_O,
  input  wire logic [IW-1:0]    PM_DATA_I,
  output var  logic [OPR_W-1:0] DM_ADDR_O,
  output var  logic             DM_RD_O,
  input  wire logic             DM_RDATA_I,
  output var  logic             DM_WR_O,
  output var  logic             DM_WDATA_O,
  output var  logic             SCAN_END_O,
  output var  logic             NO_END_O,
  output var  logic             RUNNING_O
);

  localparam logic [AW-1:0] PC_ZERO = AW'(PC_START);
  localparam logic [AW-1:0] PC_LAST = '1;

  lbx_state_t       state,    next_state;
  lbx_op_t          ir_op,    next_ir_op;
  logic [AW-1:0]    pc,       next_pc;
  logic [AW-1:0]    end_addr, next_end_addr;
  logic [AW-1:0]    pm_addr,  next_pm_addr;
  logic             pm_rd,    next_pm_rd;
  logic [OPR_W-1:0] dm_addr,  next_dm_addr;
  logic             dm_rd,    next_dm_rd;
  logic             dm_we,    next_dm_we;
  logic             dm_wdata, next_dm_wdata;
  logic             scan_end, next_scan_end;
  logic             no_end,   next_no_end;
  logic             running,  next_running;
  lbx_op_t          dec_op;
  logic [OPR_W-1:0] dec_opr;
  logic             cond;
  logic             cu_exec;

  // --------------------------------------------------------------
  // Instruction decode
  // --------------------------------------------------------------
  // Operand is one flat bit address over all data zones
  assign dec_op  = lbx_op_t'(PM_DATA_I[OPC_LSB +: OPC_W]);
  assign dec_opr = PM_DATA_I[OPR_LSB +: OPR_W];
  assign cu_exec = (state == ST_EXEC);

  lbx_cond_unit u_cond (
    .clk_i   (CLK_I),
    .reset_i (RESET_I),
    .exec_i  (cu_exec),
    .op_i    (ir_op),
    .bit_i   (DM_RDATA_I),
    .cond_o  (cond)
  );

  // --------------------------------------------------------------
  // Sequencer next values
  // --------------------------------------------------------------
  always_comb begin
    next_state    = state;
    next_ir_op    = ir_op;
    next_pc       = pc;
    next_end_addr = end_addr;
    next_pm_addr  = pm_addr;
    next_pm_rd    = 1'b0;
    next_dm_addr  = dm_addr;
    next_dm_rd    = 1'b0;
    next_dm_we    = 1'b0;
    next_dm_wdata = dm_wdata;
    next_scan_end = 1'b0;
    next_no_end   = no_end;
    next_running  = running;
    case (state)
      ST_SCAN: begin
        next_state = ST_SCAN_CHK;
      end
      ST_SCAN_CHK: begin
        if (dec_op == OP_END) begin
          next_end_addr = pc;
          next_pc       = PC_ZERO;
          next_pm_addr  = PC_ZERO;
          next_pm_rd    = 1'b1;
          next_running  = 1'b1;
          next_state    = ST_FETCH;
        end else if (pc == PC_LAST) begin
          next_no_end = 1'b1;
          next_state  = ST_HALT;
        end else begin
          next_pc      = pc + 1'b1;
          next_pm_addr = pc + 1'b1;
          next_pm_rd   = 1'b1;
          next_state   = ST_SCAN;
        end
      end
      ST_FETCH: begin
        next_state = ST_DECODE;
      end
      ST_DECODE: begin
        next_ir_op = dec_op;
        case (dec_op)
          OP_END: begin
            next_pc       = PC_ZERO;
            next_pm_addr  = PC_ZERO;
            next_pm_rd    = 1'b1;
            next_scan_end = 1'b1;
            next_state    = ST_FETCH;
          end
          OP_LOAD, OP_LOAD_INV, OP_AND, OP_AND_INV, OP_OR, OP_OR_INV: begin
            next_dm_addr = dec_opr;
            next_dm_rd   = 1'b1;
            next_state   = ST_OPERAND;
          end
          OP_OUT, OP_OUT_INV: begin
            next_dm_addr  = dec_opr;
            next_dm_we    = 1'b1;
            next_dm_wdata = cond ^ (dec_op == OP_OUT_INV);
            next_state    = ST_WRITE;
          end
          default: begin
            next_pc      = pc + 1'b1;
            next_pm_addr = pc + 1'b1;
            next_pm_rd   = 1'b1;
            next_state   = ST_FETCH;
          end
        endcase
      end
      ST_OPERAND: begin
        next_state = ST_EXEC;
      end
      ST_EXEC, ST_WRITE: begin
        next_pc      = pc + 1'b1;
        next_pm_addr = pc + 1'b1;
        next_pm_rd   = 1'b1;
        next_state   = ST_FETCH;
      end
      ST_HALT: begin
        next_state = ST_HALT;
      end
      default: begin
        next_state = ST_HALT;
      end
    endcase
  end

  // --------------------------------------------------------------
  // Sequencer registers
  // --------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state    <= STATE_RESET;
      ir_op    <= OP_NOP;
      pc       <= PC_ZERO;
      end_addr <= PC_ZERO;
      pm_addr  <= PC_ZERO;
      pm_rd    <= 1'b1;
      dm_addr  <= '0;
      dm_rd    <= 1'b0;
      dm_we    <= 1'b0;
      dm_wdata <= 1'b0;
      scan_end <= 1'b0;
      no_end   <= 1'b0;
      running  <= 1'b0;
    end else begin
      state    <= next_state;
      ir_op    <= next_ir_op;
      pc       <= next_pc;
      end_addr <= next_end_addr;
      pm_addr  <= next_pm_addr;
      pm_rd    <= next_pm_rd;
      dm_addr  <= next_dm_addr;
      dm_rd    <= next_dm_rd;
      dm_we    <= next_dm_we;
      dm_wdata <= next_dm_wdata;
      scan_end <= next_scan_end;
      no_end   <= next_no_end;
      running  <= next_running;
    end
  end

  assign PM_ADDR_O  = pm_addr;
  assign PM_RD_O    = pm_rd;
  assign DM_ADDR_O  = dm_addr;
  assign DM_RD_O    = dm_rd;
  assign DM_WR_O    = dm_we;
  assign DM_WDATA_O = dm_wdata;
  assign SCAN_END_O = scan_end;
  assign NO_END_O   = no_end;
  assign RUNNING_O  = running;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  out_value_a: assert property (@(posedge CLK_I)
    disable iff (RESET_I)
    dm_we && ir_op == OP_OUT |-> dm_wdata == cond)
    else $error("output wrote wrong value");

  out_inv_value_a: assert property (@(posedge CLK_I)
    disable iff (RESET_I)
    dm_we && ir_op == OP_OUT_INV |-> dm_wdata != cond)
    else $error("inverted output wrote wrong value");

  end_restart_a: assert property (@(posedge CLK_I)
    disable iff (RESET_I)
    state == ST_DECODE && dec_op == OP_END
    |=> pm_rd && pm_addr == PC_ZERO && scan_end)
    else $error("end did not restart at zero");

  past_end_a: assert property (@(posedge CLK_I)
    disable iff (RESET_I)
    running && pm_rd |-> pm_addr <= end_addr)
    else $error("fetch beyond first end");

  no_end_halt_a: assert property (@(posedge CLK_I)
    disable iff (RESET_I)
    no_end |=> no_end && !running && !pm_rd && !dm_rd && !dm_we)
    else $error("execution without end");

  one_word_a: assert property (@(posedge CLK_I)
    disable iff (RESET_I)
    state == ST_DECODE && dec_op inside {OP_LOAD, OP_AND, OP_OR,
      OP_LOAD_INV, OP_AND_INV, OP_OR_INV}
    |=> dm_rd && dm_addr == $past(dec_opr)
    ##2 pm_rd && pm_addr == AW'($past(pc, 3) + 1'b1))
    else $error("bit-logic step not one word");

endmodule : lbx_executor
`default_nettype wire

// *** testbench/lbx_mem_model.sv ***
/*
  Program memory and bit data memory facing the executor.
  Assumes strobes sampled on the rising clock, answer one cycle later.
*/
`default_nettype none
module lbx_mem_model
  import lbx_pkg::*;
#(
  parameter int AW = 6
) (
  input  wire logic             clk_i,
  input  wire logic [AW-1:0]    pm_addr_i,
  input  wire logic             pm_rd_i,
  output var  logic [IW-1:0]    pm_data_o,
  input  wire logic [OPR_W-1:0] dm_addr_i,
  input  wire logic             dm_rd_i,
  output var  logic             dm_rdata_o,
  input  wire logic             dm_wr_i,
  input  wire logic             dm_wdata_i
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Storage, filled by the bench
  // ------------------------------------------------------------
  logic [IW-1:0] prog [2**AW];
  logic [4095:0] dm;

  initial begin
    pm_data_o  = 16'h0000;
    dm_rdata_o = 1'b0;
  end

  // ------------------------------------------------------------
  // Answer one cycle after a strobe, else scrambled lines
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    pm_data_o  <= pm_rd_i ? prog[pm_addr_i] : ~pm_data_o;
    dm_rdata_o <= dm_rd_i ? dm[dm_addr_i] : ~dm_rdata_o;
    if (dm_wr_i) begin
      dm[dm_addr_i] <= dm_wdata_i;
    end
  end
endmodule : lbx_mem_model
`default_nettype wire

// *** testbench/tb.sv ***
/*
  Self-checking bench for the bit-logic executor with random programs.
  Assumes the memory model answers every strobe one cycle later.
*/
`default_nettype none
module tb
  import lbx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int AW = 6;
  localparam int NW = 2**AW;

  logic              CLK_I = 1'b0;
  logic              RESET_I = 1'b1;
  logic [AW-1:0]     pm_addr;
  logic              pm_rd;
  logic [IW-1:0]     pm_data;
  logic [OPR_W-1:0]  dm_addr;
  logic              dm_rd;
  logic              dm_rdata;
  logic              dm_wr;
  logic              dm_wdata;
  logic              scan_end;
  logic              no_end;
  logic              running;
  logic [IW-1:0]     prog_b [NW];
  logic [4095:0]     exp_dm;
  logic [3:0]        ops [10] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
                                  4'h7, 4'h8, 4'h0, 4'h9};
  int                fails = 0;
  int                tests_run = 0;

  always #2 CLK_I = ~CLK_I;

  lbx_executor #(.AW(AW)) dut (
    .CLK_I      (CLK_I),
    .RESET_I    (RESET_I),
    .PM_ADDR_O  (pm_addr),
    .PM_RD_O    (pm_rd),
    .PM_DATA_I  (pm_data),
    .DM_ADDR_O  (dm_addr),
    .DM_RD_O    (dm_rd),
    .DM_RDATA_I (dm_rdata),
    .DM_WR_O    (dm_wr),
    .DM_WDATA_O (dm_wdata),
    .SCAN_END_O (scan_end),
    .NO_END_O   (no_end),
    .RUNNING_O  (running)
  );

  lbx_mem_model #(.AW(AW)) u_mem (
    .clk_i      (CLK_I),
    .pm_addr_i  (pm_addr),
    .pm_rd_i    (pm_rd),
    .pm_data_o  (pm_data),
    .dm_addr_i  (dm_addr),
    .dm_rd_i    (dm_rd),
    .dm_rdata_o (dm_rdata),
    .dm_wr_i    (dm_wr),
    .dm_wdata_i (dm_wdata)
  );

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic check(input logic [4095:0] seen, input logic [4095:0] want);
    tests_run++;
    if (seen !== want) begin
      fails++;
      $display("BAD %0t value mismatch", $time);
    end
  endtask : check

  task automatic stop_test();
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // ------------------------------------------------------------
  // Reference scan over the bench copy of the program
  // ------------------------------------------------------------
  function automatic logic [4095:0] run_scan(input logic [4095:0] d);
    logic        c;
    logic [3:0]  op;
    logic [11:0] a;
    c = 1'b0;
    for (int i = 0; i < NW; i++) begin
      op = prog_b[i][15:12];
      a  = prog_b[i][11:0];
      if (op == 4'hF) break;
      case (op)
        4'h1: c = d[a];
        4'h2: c = ~d[a];
        4'h3: c = c & d[a];
        4'h4: c = c & ~d[a];
        4'h5: c = c | d[a];
        4'h6: c = c | ~d[a];
        4'h7: d[a] = c;
        4'h8: d[a] = ~c;
        default: ;
      endcase
    end
    return d;
  endfunction : run_scan

  // ------------------------------------------------------------
  // Program build, junk after end writes the marker bit
  // ------------------------------------------------------------
  task automatic make_prog(input int n, input bit has_end);
    for (int i = 0; i < NW; i++) begin
      prog_b[i] = (i < n) ? {ops[$urandom_range(9)],
                             12'($urandom_range(4094))} : 16'h7FFF;
    end
    if (n > 0) prog_b[0][15:12] = 4'($urandom_range(2, 1));
    if (has_end) prog_b[n] = 16'hF000;
    for (int i = 0; i < NW; i++) u_mem.prog[i] = prog_b[i];
    for (int i = 0; i < 128; i++) exp_dm[i*32 +: 32] = $urandom;
    u_mem.dm = exp_dm;
  endtask : make_prog

  task automatic wait_end();
    int k;
    k = 0;
    do begin
      @(negedge CLK_I);
      k++;
    end while (scan_end !== 1'b1 && k < 2000);
    check(scan_end, 1'b1);
  endtask : wait_end

  task automatic run_prog(input int n, input bit has_end);
    logic [4095:0] init;
    @(posedge CLK_I);
    RESET_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
    @(negedge CLK_I);
    make_prog(n, has_end);
    init = exp_dm;
    @(posedge CLK_I);
    RESET_I <= 1'b0;
    if (has_end) begin
      repeat (2) begin
        exp_dm = run_scan(exp_dm);
        wait_end();
        check(u_mem.dm, exp_dm);
        check({running, no_end}, 2'h2);
      end
    end else begin
      repeat (300) @(negedge CLK_I);
      check({running, no_end}, 2'h1);
      check(u_mem.dm, init);
    end
  endtask : run_prog

  // Junk after the first end must never write
  always @(negedge CLK_I) begin
    if (RESET_I === 1'b0) begin
      check(dm_wr === 1'b1 && dm_addr === 12'hFFF, 1'b0);
    end
  end

  initial begin
    #(100000);
    fails++;
    stop_test();
  end

  initial begin
    void'($urandom(81));
    run_prog(0, 1'b1);
    run_prog(NW - 1, 1'b1);
    run_prog(20, 1'b0);
    for (int k = 0; k < 14; k++) begin
      run_prog($urandom_range(40, 1), 1'b1);
    end
    stop_test();
  end
endmodule : tb
`default_nettype wire
